// ==== pkg/ivd_pkg.sv ====
// Constants for the serial-bus setpoint receiver
// Function
// R1: Six-bit code maps linearly onto 0.69V to 2.05V, 21.6mV per step.
// R2: After enable the code is 100000 (1.38V) until a new write.
// R3: Output moves toward a new code only after the frame ends with STOP.
// R4: External start-up feedback rules until a write completes with STOP.
// R5: After the first update the DAC stays reference until disable and enable.
// R6: Unused start-up feature means feedback sense input tied to input supply.
// R7: Write only; no readable data is ever offered to the master.
// R8: The clock line is never driven low; no clock stretching.
// R9: START is data falling with clock high; STOP is data rising with clock high.
// R10: Master leaves both lines released high while the bus is idle.
// R11: Transfers are 9-bit segments, byte MSB first then one acknowledge bit.
// R12: First byte holds 7-bit address and direction flag; addressed slave acks.
// R13: Respond only to a transfer that starts with our own address.
// R14: Master clocks the acknowledge pulse and releases data during it.
// R15: Data line held low through the whole acknowledge clock pulse.
// R16: On a not-acknowledge the master ends the transfer with STOP.
// R17: Only address-write plus one data byte, each acknowledged.
// R18: Data committed only on valid STOP; frames without STOP are discarded.
// R19: Address mismatch or read request leaves data released until next START.
// R20: START or STOP mid-byte aborts the frame without touching the setpoint; a STOP inside a byte sent after the acked data byte still commits.
// ****************************************************************
// Package
// ****************************************************************
package ivd_pkg;
   localparam logic [6:0] IVD_SLAVE_ADDR   = 7'h1a; // Arbitrary value
   localparam logic [5:0] IVD_CODE_RESET   = 6'h20;
   localparam int         IVD_CODE_W       = 6;
   localparam int         IVD_MV_MIN_X10   = 6900;
   localparam int         IVD_MV_STEP_X10  = 216;
   localparam logic [3:0] IVD_ACK_BIT      = 4'h8;
   localparam logic [3:0] IVD_BIT_ZERO     = 4'h0;
   typedef enum logic [2:0] {IVD_IDLE, IVD_ADDR, IVD_ACK_A, IVD_DATA, IVD_ACK_D, IVD_WAIT, IVD_IGNORE} ivd_state_t;
endpackage : ivd_pkg

// ==== hw/ivd_setpoint.sv ====
// Serial-bus setpoint receiver driving the internal voltage DAC code
`timescale 1ns/1ps
module ivd_setpoint
   import ivd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_out,
   output logic            scl_oe,
   output logic            sda_out,
   output logic            sda_oe,
   output logic [5:0]      dac_code,
   output logic            use_internal_fb,
   output logic            update_pulse
);
   // ****************************************************************
   // Bus sampling
   // ****************************************************************
   logic       scl_d_ff;
   logic       sda_d_ff;
   logic       scl_q_ff;
   logic       sda_q_ff;
   ivd_state_t state_ff;
   ivd_state_t nxt_state;
   logic [3:0] bit_cnt_ff;
   logic [3:0] nxt_bit_cnt;
   logic [7:0] shift_ff;
   logic [7:0] nxt_shift;
   logic [5:0] pend_ff;
   logic [5:0] nxt_pend;
   logic       pend_vld_ff;
   logic       nxt_pend_vld;
   logic [5:0] code_ff;
   logic [5:0] nxt_code;
   logic       int_fb_ff;
   logic       nxt_int_fb;
   logic       upd_ff;
   logic       nxt_upd;
   logic       sda_low_ff;
   logic       nxt_sda_low;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else if (ce) begin
         scl_d_ff <= scl_in;
         sda_d_ff <= sda_in;
         scl_q_ff <= scl_d_ff;
         sda_q_ff <= sda_d_ff;
      end
   end

   assign scl_rise  = scl_d_ff & ~scl_q_ff;
   assign scl_fall  = ~scl_d_ff & scl_q_ff;
   assign start_det = scl_d_ff & scl_q_ff & sda_q_ff & ~sda_d_ff; // see R9
   assign stop_det  = scl_d_ff & scl_q_ff & ~sda_q_ff & sda_d_ff; // see R9

   // ****************************************************************
   // Receive state machine
   // ****************************************************************
   always_comb begin
      nxt_state    = state_ff;
      nxt_bit_cnt  = bit_cnt_ff;
      nxt_shift    = shift_ff;
      nxt_pend     = pend_ff;
      nxt_pend_vld = pend_vld_ff;
      nxt_code     = code_ff;
      nxt_int_fb   = int_fb_ff;
      nxt_upd      = 1'b0;
      nxt_sda_low  = sda_low_ff;
      if (start_det) begin
         nxt_state    = IVD_ADDR; // see R20
         nxt_bit_cnt  = IVD_BIT_ZERO;
         nxt_pend_vld = 1'b0; // see R18
         nxt_sda_low  = 1'b0;
      end else if (stop_det) begin
         if (state_ff == IVD_WAIT && pend_vld_ff) begin
            nxt_code   = pend_ff; // see R3
            nxt_int_fb = 1'b1; // see R4
            nxt_upd    = 1'b1;
         end
         nxt_state    = IVD_IDLE; // see R18
         nxt_pend_vld = 1'b0;
         nxt_sda_low  = 1'b0;
      end else begin
         unique case (state_ff)
            IVD_IDLE, IVD_WAIT, IVD_IGNORE: begin
               nxt_sda_low = 1'b0; // see R19
            end
            IVD_ADDR, IVD_DATA: begin
               if (scl_rise) begin
                  nxt_shift   = {shift_ff[6:0], sda_d_ff}; // see R11
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
               end
               if (scl_fall && bit_cnt_ff == IVD_ACK_BIT) begin
                  if (state_ff == IVD_ADDR) begin
                     if (shift_ff[7:1] == IVD_SLAVE_ADDR && !shift_ff[0]) begin // see R13
                        nxt_state   = IVD_ACK_A; // see R12
                        nxt_sda_low = 1'b1; // see R7
                     end else begin
                        nxt_state = IVD_IGNORE; // see R19
                     end
                  end else begin
                     nxt_pend    = shift_ff[5:0]; // see R17
                     nxt_state   = IVD_ACK_D;
                     nxt_sda_low = 1'b1;
                  end
               end
            end
            IVD_ACK_A, IVD_ACK_D: begin
               if (scl_fall) begin
                  nxt_sda_low = 1'b0; // see R15
                  nxt_bit_cnt = IVD_BIT_ZERO;
                  if (state_ff == IVD_ACK_A) begin
                     nxt_state = IVD_DATA;
                  end else begin
                     nxt_state    = IVD_WAIT; // see R17
                     nxt_pend_vld = 1'b1;
                  end
               end
            end
            default: nxt_state = IVD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff    <= IVD_IDLE;
         bit_cnt_ff  <= IVD_BIT_ZERO;
         shift_ff    <= 8'h00;
         pend_ff     <= 6'h00;
         pend_vld_ff <= 1'b0;
         code_ff     <= IVD_CODE_RESET; // see R2
         int_fb_ff   <= 1'b0; // see R5
         upd_ff      <= 1'b0;
         sda_low_ff  <= 1'b0;
      end else if (ce) begin
         state_ff    <= nxt_state;
         bit_cnt_ff  <= nxt_bit_cnt;
         shift_ff    <= nxt_shift;
         pend_ff     <= nxt_pend;
         pend_vld_ff <= nxt_pend_vld;
         code_ff     <= nxt_code; // see R1
         int_fb_ff   <= nxt_int_fb; // see R5
         upd_ff      <= nxt_upd;
         sda_low_ff  <= nxt_sda_low;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign scl_out         = 1'b0;
   assign scl_oe          = 1'b0; // see R8
   assign sda_out         = 1'b0;
   assign sda_oe          = sda_low_ff;
   assign dac_code        = code_ff;
   assign use_internal_fb = int_fb_ff;
   assign update_pulse    = upd_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_SCL_NEVER: assert property (@(posedge clk) disable iff (!rst_b) !scl_oe) // see R8
      else $error("clock line driven");
   AST_CODE_ONLY_ON_STOP: assert property (@(posedge clk) disable iff (!rst_b) // see R3
      (ce && code_ff != nxt_code) |-> stop_det)
      else $error("code changed without stop");
   AST_FB_STICKY: assert property (@(posedge clk) disable iff (!rst_b) // see R5
      use_internal_fb |=> use_internal_fb)
      else $error("internal feedback dropped");
   AST_FB_FOLLOWS_UPD: assert property (@(posedge clk) disable iff (!rst_b) // see R4
      update_pulse |-> use_internal_fb)
      else $error("update without feedback switch");
   AST_ACK_HELD: assert property (@(posedge clk) disable iff (!rst_b) // see R15
      (sda_oe && scl_d_ff && !start_det && !stop_det) |=> sda_oe)
      else $error("ack released while clock high");
   AST_IGNORE_QUIET: assert property (@(posedge clk) disable iff (!rst_b) // see R19
      (state_ff == IVD_IGNORE) |-> !sda_oe)
      else $error("driving while ignoring");
   AST_START_ABORT: assert property (@(posedge clk) disable iff (!rst_b) // see R20
      (ce && start_det) |=> (state_ff == IVD_ADDR && !pend_vld_ff && $stable(code_ff)))
      else $error("start did not abort");
   AST_RESET_CODE: assert property (@(posedge clk) $rose(rst_b) |-> dac_code == IVD_CODE_RESET) // see R2
      else $error("reset code wrong");
   AST_NO_COMMIT_NO_DATA: assert property (@(posedge clk) disable iff (!rst_b) // see R18
      (ce && stop_det && !pend_vld_ff) |=> $stable(code_ff))
      else $error("commit without data");
   AST_READ_NO_ACK: assert property (@(posedge clk) disable iff (!rst_b) // see R7
      (ce && state_ff == IVD_ADDR && scl_fall && bit_cnt_ff == IVD_ACK_BIT
       && shift_ff[0]) |=> !sda_oe)
      else $error("read request acknowledged");
   AST_FOREIGN_NO_ACK: assert property (@(posedge clk) disable iff (!rst_b) // see R13
      (ce && state_ff == IVD_ADDR && scl_fall && bit_cnt_ff == IVD_ACK_BIT
       && shift_ff[7:1] != IVD_SLAVE_ADDR) |=> !sda_oe)
      else $error("foreign address acknowledged");
   AST_ACK_IN_SLOT: assert property (@(posedge clk) disable iff (!rst_b) // see R15
      sda_oe |-> (state_ff == IVD_ACK_A || state_ff == IVD_ACK_D))
      else $error("data line driven outside an acknowledge slot");
   AST_BITCNT_RANGE: assert property (@(posedge clk) disable iff (!rst_b) // see R11
      bit_cnt_ff <= IVD_ACK_BIT)
      else $error("bit counter beyond the acknowledge bit");
   AST_UPD_SINGLE: assert property (@(posedge clk) disable iff (!rst_b) // see R3
      (ce && update_pulse) |=> !update_pulse)
      else $error("update pulse longer than one cycle");
   AST_COMMIT_PEND: assert property (@(posedge clk) disable iff (!rst_b) // see R18
      update_pulse |-> dac_code == $past(pend_ff))
      else $error("committed code differs from received byte");
   AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!rst_b) // see R3
      !ce |=> ($stable(state_ff) && $stable(code_ff) && $stable(sda_oe)))
      else $error("state moved while clock enable low");
   COV_UPDATE: cover property (@(posedge clk) disable iff (!rst_b) update_pulse);
   COV_ADDR_ACK: cover property (@(posedge clk) disable iff (!rst_b) state_ff == IVD_ACK_A);
   COV_IGNORE: cover property (@(posedge clk) disable iff (!rst_b) state_ff == IVD_IGNORE);
   COV_ABORT: cover property (@(posedge clk) disable iff (!rst_b) state_ff == IVD_DATA && start_det);
   COV_STOP_MID_BYTE: cover property (@(posedge clk) disable iff (!rst_b) state_ff == IVD_DATA && stop_det);
endmodule : ivd_setpoint

// ==== bench/ivd_master.sv ====
// Bus master model driving the serial clock and data lines
`timescale 1ns/1ps
module ivd_master (
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda
);
   localparam int Q = 6;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic drv(input logic c, input logic d);
      scl <= c;
      sda <= d;
      repeat (Q) @(posedge clk);
   endtask : drv
   task automatic start();
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      drv(1'b1, 1'b0);
      drv(1'b0, 1'b0);
   endtask : start
   task automatic stop();
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b1);
   endtask : stop
   task automatic bit_out(input logic b);
      drv(1'b0, b);
      drv(1'b1, b);
      drv(1'b1, b);
   endtask : bit_out
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic a0;
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      a0 = sda_line;
      drv(1'b1, 1'b1);
      ack = ~a0 & ~sda_line;
      drv(1'b0, 1'b1);
   endtask : wbyte
endmodule : ivd_master

// ==== bench/ivd_setpoint_tb.sv ====
// Self-checking testbench for the setpoint receiver
`timescale 1ns/1ps
module ivd_setpoint_tb;
   import ivd_pkg::*;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       ce = 1'b1;
   logic       m_scl, m_sda, scl_out, scl_oe, sda_out, sda_oe, use_internal_fb, update_pulse;
   logic [5:0] dac_code;
   logic [5:0] exp_code = IVD_CODE_RESET;
   logic       exp_fb = 1'b0;
   int         n_errors = 0;
   int         compares = 0;
   int         n_upd = 0;
   int         n_exp = 0;
   wire        scl_in = m_scl & ~scl_oe;
   wire        sda_in = m_sda & ~sda_oe;
   always #2 clk = ~clk;
   always @(posedge clk) if (update_pulse === 1'b1) n_upd++;
   ivd_setpoint dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .dac_code(dac_code),
      .use_internal_fb(use_internal_fb), .update_pulse(update_pulse));
   ivd_master m_u (.clk(clk), .sda_line(sda_in), .scl(m_scl), .sda(m_sda));
   function automatic logic [5:0] code_of(input logic [7:0] d);
      return d[5:0];
   endfunction : code_of
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic stp, input logic ea);
      logic k;
      m_u.start();
      m_u.wbyte(a, k);
      check(k, ea);
      check(scl_oe, 1'b0);
      check(scl_out, 1'b0);
      check(sda_out, 1'b0);
      if (ea) begin
         m_u.wbyte(d, k);
         check(k, 1'b1);
      end
      check(dac_code, exp_code);
      if (stp || !ea) m_u.stop();
      repeat (4) @(posedge clk);
      if (stp && ea) begin
         exp_code = code_of(d);
         exp_fb = 1'b1;
         n_exp++;
      end
      check(dac_code, exp_code);
      check(use_internal_fb, exp_fb);
   endtask : frame
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      finish_test();
   end
   initial begin
      logic [7:0] d;
      logic       k;
      void'($urandom(43));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check(dac_code, IVD_CODE_RESET);
      check(use_internal_fb, 1'b0);
      ce <= 1'b0;
      m_u.start();
      m_u.wbyte({IVD_SLAVE_ADDR, 1'b0}, k);
      m_u.stop();
      ce <= 1'b1;
      check(k, 1'b0);
      check(dac_code, exp_code);
      for (int i = 0; i < 16; i++) begin
         d = 8'($urandom);
         case (i % 4)
            0: frame({IVD_SLAVE_ADDR, 1'b0}, d, 1'b1, 1'b1);
            1: frame({IVD_SLAVE_ADDR ^ 7'(1 + $urandom % 127), 1'b0}, d, 1'b1, 1'b0);
            2: frame({IVD_SLAVE_ADDR, 1'b1}, d, 1'b1, 1'b0);
            default: frame({IVD_SLAVE_ADDR, 1'b0}, d, 1'b0, 1'b1);
         endcase
      end
      m_u.start();
      m_u.wbyte({IVD_SLAVE_ADDR, 1'b0}, k);
      check(k, 1'b1);
      for (int i = 0; i < 3; i++) m_u.bit_out(1'b1);
      m_u.stop();
      repeat (4) @(posedge clk);
      check(dac_code, exp_code);
      check(n_upd[7:0], n_exp[7:0]);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check(dac_code, IVD_CODE_RESET);
      check(use_internal_fb, 1'b0);
      finish_test();
   end
endmodule : ivd_setpoint_tb
